// *** hw/fsp_top.v ***
// Host-side controller that polls a NOR flash's write-operation status
`timescale 1ns/1ps
`default_nettype none
`include "fsp_defs.vh"
// Function
// - Host polls at the programmed address during a program.
// - Host polls erase status at an address inside a selected sector.
// - Host takes full byte from a read after polling showed completion.
// - Host polls buffered writes at the last loaded buffer address.
// - Host does two back-to-back reads and compares toggle one.
// - Toggling with timeout set: recheck, then fail and issue reset.
// - Host restarts toggle check from the first step after a pause.
// - After buffer abort, host issues the abort reset sequence.
module fsp_top #(
  parameter AW = 12,
  parameter DW = 8
) (
  // Clock and reset
  input  wire          clk_sys_i,
  input  wire          rstn_i,
  // Software port
  input  wire [3:0]    sw_addr_i,
  input  wire [15:0]   sw_wdata_i,
  input  wire          sw_wr_i,
  input  wire          sw_rd_i,
  output reg  [15:0]   sw_rdata_o,
  // Flash pins
  output wire [AW-1:0] fl_addr_o,
  output wire [DW-1:0] fl_dq_o,
  output wire          fl_dq_oe_o,
  input  wire [DW-1:0] fl_dq_i,
  output wire          fl_ce_n_o,
  output wire          fl_oe_n_o,
  output wire          fl_we_n_o,
  input  wire          fl_ready_busy_n_i
);
  localparam integer HOLD_N = (`FSP_ACCESS_NS + `FSP_CLK_NS - 1) / `FSP_CLK_NS;
  localparam [3:0]   HOLD   = HOLD_N[3:0];
  localparam [2:0] S_IDLE = 3'h0;
  localparam [2:0] S_RD1  = 3'h1;
  localparam [2:0] S_RD2  = 3'h2;
  localparam [2:0] S_RD3  = 3'h3;
  localparam [2:0] S_DATA = 3'h4;
  localparam [2:0] S_RST  = 3'h5;
  localparam [2:0] S_WR   = 3'h6;

  reg [2:0]    state_reg;
  reg          mode_reg;
  reg          abort_rst_reg;
  reg [AW-1:0] target_reg;
  reg [DW-1:0] expect_reg;
  reg [DW-1:0] first_reg;
  reg [DW-1:0] last_reg;
  reg [DW-1:0] data_reg;
  reg [1:0]    result_reg;
  reg          timeout_seen_reg;
  reg          abort_seen_reg;
  reg [1:0]    seq_reg;
  reg [AW-1:0] cmd_addr_reg;
  reg [DW-1:0] cmd_data_reg;
  reg          go_reg;
  reg          wr_reg;
  reg [AW-1:0] cyc_addr_reg;
  reg [DW-1:0] cyc_data_reg;
  reg          rb_reg;
  wire         cyc_done;
  wire [DW-1:0] cyc_rdata;
  wire [AW+DW-1:0] rst_first;
  wire [AW+DW-1:0] rst_step;

  fsp_bus_cycle #(
    .AW   (AW),
    .DW   (DW),
    .CW   (4),
    .HOLD (HOLD)
  ) u_cycle (
    .clk_sys_i  (clk_sys_i),
    .rstn_i     (rstn_i),
    .go_i       (go_reg),
    .wr_i       (wr_reg),
    .addr_i     (cyc_addr_reg),
    .wdata_i    (cyc_data_reg),
    .done_o     (cyc_done),
    .rdata_o    (cyc_rdata),
    .fl_addr_o  (fl_addr_o),
    .fl_dq_o    (fl_dq_o),
    .fl_dq_oe_o (fl_dq_oe_o),
    .fl_dq_i    (fl_dq_i),
    .fl_ce_n_o  (fl_ce_n_o),
    .fl_oe_n_o  (fl_oe_n_o),
    .fl_we_n_o  (fl_we_n_o)
  );

  // True when two status reads show toggle one unchanged
  function still;
    input [DW-1:0] a;
    input [DW-1:0] b;
    begin
      still = (a[`FSP_BIT_TOG1] == b[`FSP_BIT_TOG1]);
    end
  endfunction

  // True when the polling bit matches the written datum
  function poll_ok;
    input [DW-1:0] s;
    input [DW-1:0] e;
    begin
      poll_ok = (s[`FSP_BIT_POLL] == e[`FSP_BIT_POLL]);
    end
  endfunction

  // Command words for the abort-reset or plain reset sequence
  function [AW+DW-1:0] rst_word;
    input [1:0] n;
    input       abort;
    begin
      if (abort && n == 2'h0)
        rst_word = {`FSP_UNLOCK1_ADDR, `FSP_UNLOCK1_DATA};
      else if (abort && n == 2'h1)
        rst_word = {`FSP_UNLOCK2_ADDR, `FSP_UNLOCK2_DATA};
      else
        rst_word = {`FSP_UNLOCK1_ADDR, `FSP_RESET_DATA};
    end
  endfunction

  // First word of the recovery sequence and the word after the current step
  assign rst_first = rst_word(2'h0, abort_seen_reg);
  assign rst_step  = rst_word(seq_reg + 2'h1, 1'b1);

  ////////////////////////////////////////////////////////////////////////
  // Software port: read data in the cycle after the strobe
  always @(posedge clk_sys_i)
  begin
    if (!rstn_i)
      sw_rdata_o <= 16'h0000;
    else if (sw_rd_i)
    begin
      if (sw_addr_i == `FSP_ADDR_CTRL)
        sw_rdata_o <= {13'h0000, abort_rst_reg, mode_reg, 1'b0};
      else if (sw_addr_i == `FSP_ADDR_TARGET)
        sw_rdata_o <= {{(16-AW){1'b0}}, target_reg};
      else if (sw_addr_i == `FSP_ADDR_EXPECT)
        sw_rdata_o <= {{(16-DW){1'b0}}, expect_reg};
      else if (sw_addr_i == `FSP_ADDR_STATUS)
        sw_rdata_o <= {11'h000, rb_reg, abort_seen_reg, timeout_seen_reg, result_reg};
      else if (sw_addr_i == `FSP_ADDR_LASTST)
        sw_rdata_o <= {{(16-DW){1'b0}}, last_reg};
      else if (sw_addr_i == `FSP_ADDR_DATA)
        sw_rdata_o <= {{(16-DW){1'b0}}, data_reg};
      else if (sw_addr_i == `FSP_ADDR_CMDADR)
        sw_rdata_o <= {{(16-AW){1'b0}}, cmd_addr_reg};
      else if (sw_addr_i == `FSP_ADDR_CMDDAT)
        sw_rdata_o <= {{(16-DW){1'b0}}, cmd_data_reg};
      else
        sw_rdata_o <= 16'h0000;
    end
    else
      sw_rdata_o <= 16'h0000;
  end

  ////////////////////////////////////////////////////////////////////////
  // Poll engine
  always @(posedge clk_sys_i)
  begin
    go_reg <= 1'b0;
    if (!rstn_i)
    begin
      state_reg        <= S_IDLE;
      mode_reg         <= `FSP_MODE_TOGGLE;
      abort_rst_reg    <= 1'b0;
      target_reg       <= {AW{1'b0}};
      expect_reg       <= {DW{1'b0}};
      first_reg        <= {DW{1'b0}};
      last_reg         <= {DW{1'b0}};
      data_reg         <= {DW{1'b0}};
      result_reg       <= `FSP_RES_IDLE;
      timeout_seen_reg <= 1'b0;
      abort_seen_reg   <= 1'b0;
      seq_reg          <= 2'h0;
      cmd_addr_reg     <= {AW{1'b0}};
      cmd_data_reg     <= {DW{1'b0}};
      wr_reg           <= 1'b0;
      cyc_addr_reg     <= {AW{1'b0}};
      cyc_data_reg     <= {DW{1'b0}};
      rb_reg           <= 1'b1;
    end
    else
    begin
      rb_reg <= fl_ready_busy_n_i;
      if (sw_wr_i && sw_addr_i == `FSP_ADDR_TARGET)
        target_reg <= sw_wdata_i[AW-1:0];
      else if (sw_wr_i && sw_addr_i == `FSP_ADDR_EXPECT)
        expect_reg <= sw_wdata_i[DW-1:0];
      else if (sw_wr_i && sw_addr_i == `FSP_ADDR_CMDADR)
        cmd_addr_reg <= sw_wdata_i[AW-1:0];
      else if (sw_wr_i && sw_addr_i == `FSP_ADDR_CMDDAT)
        cmd_data_reg <= sw_wdata_i[DW-1:0];
      case (state_reg)
        S_IDLE:
        begin
          if (sw_wr_i && sw_addr_i == `FSP_ADDR_CTRL)
          begin
            mode_reg      <= sw_wdata_i[`FSP_CTRL_MODE];
            abort_rst_reg <= sw_wdata_i[`FSP_CTRL_ABORTRST];
            if (sw_wdata_i[`FSP_CTRL_WRITE])
            begin
              // Raw command write lets software issue program or erase words
              wr_reg       <= 1'b1;
              cyc_addr_reg <= cmd_addr_reg;
              cyc_data_reg <= cmd_data_reg;
              go_reg       <= 1'b1;
              state_reg    <= S_WR;
            end
            else if (sw_wdata_i[`FSP_CTRL_START])
            begin
              // Fresh start every time: a paused check restarts here
              result_reg       <= `FSP_RES_BUSY;
              timeout_seen_reg <= 1'b0;
              abort_seen_reg   <= 1'b0;
              wr_reg           <= 1'b0;
              cyc_addr_reg     <= target_reg;
              go_reg           <= 1'b1;
              state_reg        <= S_RD1;
            end
          end
        end
        S_WR:
          if (cyc_done)
            state_reg <= S_IDLE;
        S_RD1:
          if (cyc_done)
          begin
            first_reg <= cyc_rdata;
            last_reg  <= cyc_rdata;
            go_reg    <= 1'b1;
            state_reg <= S_RD2;
          end
        S_RD2:
          if (cyc_done)
          begin
            last_reg <= cyc_rdata;
            if (mode_reg == `FSP_MODE_POLL ? poll_ok(cyc_rdata, expect_reg)
                                           : still(first_reg, cyc_rdata))
            begin
              go_reg    <= 1'b1;
              state_reg <= S_DATA;
            end
            else if (cyc_rdata[`FSP_BIT_TIMEOUT] || cyc_rdata[`FSP_BIT_BUFABORT])
            begin
              // Bit may have stopped just as the flag rose: read once more
              timeout_seen_reg <= cyc_rdata[`FSP_BIT_TIMEOUT];
              abort_seen_reg   <= cyc_rdata[`FSP_BIT_BUFABORT];
              first_reg        <= cyc_rdata;
              go_reg           <= 1'b1;
              state_reg        <= S_RD3;
            end
            else
            begin
              first_reg <= cyc_rdata;
              go_reg    <= 1'b1;
            end
          end
        S_RD3:
          if (cyc_done)
          begin
            last_reg <= cyc_rdata;
            if (mode_reg == `FSP_MODE_POLL ? poll_ok(cyc_rdata, expect_reg)
                                           : still(first_reg, cyc_rdata))
            begin
              // Toggle stopped or polling bit matched: the operation finished, so any flag seen was not a failure
              timeout_seen_reg <= 1'b0;
              abort_seen_reg   <= 1'b0;
              go_reg           <= 1'b1;
              state_reg        <= S_DATA;
            end
            else
            begin
              // Failed operation: reset back to array reads
              result_reg   <= `FSP_RES_FAIL;
              seq_reg      <= 2'h0;
              wr_reg       <= 1'b1;
              cyc_addr_reg <= rst_first[AW+DW-1:DW];
              cyc_data_reg <= rst_first[DW-1:0];
              go_reg       <= 1'b1;
              state_reg    <= S_RST;
            end
          end
        S_DATA:
          if (cyc_done)
          begin
            data_reg   <= cyc_rdata;
            result_reg <= `FSP_RES_DONE;
            state_reg  <= S_IDLE;
          end
        S_RST:
          if (cyc_done)
          begin
            if (abort_seen_reg && seq_reg != 2'h2)
            begin
              seq_reg      <= seq_reg + 2'h1;
              cyc_addr_reg <= rst_step[AW+DW-1:DW];
              cyc_data_reg <= rst_step[DW-1:0];
              go_reg       <= 1'b1;
            end
            else
            begin
              wr_reg    <= 1'b0;
              state_reg <= S_IDLE;
            end
          end
        default:
          state_reg <= S_IDLE;
      endcase
    end
  end
endmodule
`default_nettype wire

// *** hw/fsp_defs.vh ***
// Constants for the flash status poller controller
`ifndef FSP_DEFS_VH
`define FSP_DEFS_VH
// Register indices on the software port
`define FSP_ADDR_CTRL     4'h0
`define FSP_ADDR_TARGET   4'h1
`define FSP_ADDR_EXPECT   4'h2
`define FSP_ADDR_STATUS   4'h3
`define FSP_ADDR_LASTST   4'h4
`define FSP_ADDR_DATA     4'h5
`define FSP_ADDR_CMDADR   4'h6
`define FSP_ADDR_CMDDAT   4'h7
// Control register fields
`define FSP_CTRL_START    0
`define FSP_CTRL_MODE     1
`define FSP_CTRL_ABORTRST 2
`define FSP_CTRL_WRITE    3
// Mode encodings
`define FSP_MODE_TOGGLE   1'b0
`define FSP_MODE_POLL     1'b1
// Status byte bit positions
`define FSP_BIT_POLL      7
`define FSP_BIT_TOG1      6
`define FSP_BIT_TIMEOUT   5
`define FSP_BIT_EWIN      3
`define FSP_BIT_TOG2      2
`define FSP_BIT_BUFABORT  1
// Result codes
`define FSP_RES_IDLE      2'h0
`define FSP_RES_BUSY      2'h1
`define FSP_RES_DONE      2'h2
`define FSP_RES_FAIL      2'h3
// Flash bus timing
`define FSP_ACCESS_NS     90
`define FSP_CLK_NS        20
// Reset and abort-reset command words
`define FSP_RESET_DATA    8'hF0
`define FSP_UNLOCK1_ADDR  12'h555
`define FSP_UNLOCK1_DATA  8'hAA
`define FSP_UNLOCK2_ADDR  12'h2AA
`define FSP_UNLOCK2_DATA  8'h55
`endif

// *** hw/fsp_bus_cycle.v ***
// One asynchronous flash read or write cycle, paced from the system clock
`timescale 1ns/1ps
`default_nettype none
`include "fsp_defs.vh"
module fsp_bus_cycle #(
  parameter AW = 12,
  parameter DW = 8,
  parameter CW = 4,
  parameter [CW-1:0] HOLD = 4'h5
) (
  // Clock and reset
  input  wire          clk_sys_i,
  input  wire          rstn_i,
  // Request side
  input  wire          go_i,
  input  wire          wr_i,
  input  wire [AW-1:0] addr_i,
  input  wire [DW-1:0] wdata_i,
  output reg           done_o,
  output reg  [DW-1:0] rdata_o,
  // Flash pins
  output reg  [AW-1:0] fl_addr_o,
  output reg  [DW-1:0] fl_dq_o,
  output reg           fl_dq_oe_o,
  input  wire [DW-1:0] fl_dq_i,
  output reg           fl_ce_n_o,
  output reg           fl_oe_n_o,
  output reg           fl_we_n_o
);
  reg [CW-1:0] cnt_reg;
  reg          busy_reg;

  // Each cycle ends by raising every strobe, so status is sampled per edge
  always @(posedge clk_sys_i)
  begin
    done_o <= 1'b0;
    if (!rstn_i)
    begin
      busy_reg   <= 1'b0;
      cnt_reg    <= {CW{1'b0}};
      rdata_o    <= {DW{1'b0}};
      fl_addr_o  <= {AW{1'b0}};
      fl_dq_o    <= {DW{1'b0}};
      fl_dq_oe_o <= 1'b0;
      fl_ce_n_o  <= 1'b1;
      fl_oe_n_o  <= 1'b1;
      fl_we_n_o  <= 1'b1;
    end
    else if (!busy_reg)
    begin
      if (go_i)
      begin
        busy_reg   <= 1'b1;
        cnt_reg    <= HOLD;
        fl_addr_o  <= addr_i;
        fl_dq_o    <= wdata_i;
        fl_dq_oe_o <= wr_i;
        fl_ce_n_o  <= 1'b0;
        fl_oe_n_o  <= wr_i;
        fl_we_n_o  <= ~wr_i;
      end
    end
    else if (cnt_reg != {CW{1'b0}})
      cnt_reg <= cnt_reg - {{(CW-1){1'b0}}, 1'b1};
    else
    begin
      busy_reg   <= 1'b0;
      done_o     <= 1'b1;
      rdata_o    <= fl_dq_i;
      fl_dq_oe_o <= 1'b0;
      fl_ce_n_o  <= 1'b1;
      fl_oe_n_o  <= 1'b1;
      fl_we_n_o  <= 1'b1;
    end
  end
endmodule
`default_nettype wire

// *** tb/fsp_top_chk.sv ***
// Assertions on the flash status poller's software port and flash pins
`timescale 1ns/1ps
`default_nettype none
module fsp_top_chk #(
  parameter AW = 12,
  parameter DW = 8
) (
  input wire logic          clk_sys_i,
  input wire logic          rstn_i,
  input wire logic          sw_rd_i,
  input wire logic [15:0]   sw_rdata_o,
  input wire logic [AW-1:0] fl_addr_o,
  input wire logic          fl_dq_oe_o,
  input wire logic          fl_ce_n_o,
  input wire logic          fl_oe_n_o,
  input wire logic          fl_we_n_o
);
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!rstn_i);
  property p_rd_idle; !$past(sw_rd_i) |-> sw_rdata_o == 16'h0000; endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data outside read slot");
  property p_no_clash; !(!fl_oe_n_o && !fl_we_n_o); endproperty
  a_no_clash: assert property (p_no_clash) else $error("read and write strobes together");
  property p_sel; (!fl_oe_n_o || !fl_we_n_o) |-> !fl_ce_n_o; endproperty
  a_sel: assert property (p_sel) else $error("strobe without chip select");
  property p_quiet; !fl_oe_n_o |-> !fl_dq_oe_o; endproperty
  a_quiet: assert property (p_quiet) else $error("data driven during a read");
  property p_drive; !fl_we_n_o |-> fl_dq_oe_o; endproperty
  a_drive: assert property (p_drive) else $error("write without data");
  // Each read is a separate strobe, so the device sees one toggle step per read
  property p_rd_len; $fell(fl_oe_n_o) |-> !fl_oe_n_o [*6] ##1 fl_oe_n_o; endproperty
  a_rd_len: assert property (p_rd_len) else $error("read strobe length wrong");
  property p_wr_len; $fell(fl_we_n_o) |-> !fl_we_n_o [*6] ##1 fl_we_n_o; endproperty
  a_wr_len: assert property (p_wr_len) else $error("write strobe length wrong");
  property p_addr; (!fl_ce_n_o && !$past(fl_ce_n_o)) |-> $stable(fl_addr_o); endproperty
  a_addr: assert property (p_addr) else $error("address moved in a cycle");
endmodule
bind fsp_top fsp_top_chk #(.AW(AW), .DW(DW)) i_fsp_top_chk (
  .clk_sys_i(clk_sys_i),
  .rstn_i(rstn_i),
  .sw_rd_i(sw_rd_i),
  .sw_rdata_o(sw_rdata_o),
  .fl_addr_o(fl_addr_o),
  .fl_dq_oe_o(fl_dq_oe_o),
  .fl_ce_n_o(fl_ce_n_o),
  .fl_oe_n_o(fl_oe_n_o),
  .fl_we_n_o(fl_we_n_o)
);
`default_nettype wire

// *** tb/fsp_flash_model.sv ***
// Behavioural NOR flash that answers status reads during embedded operations
`timescale 1ns/1ps
`default_nettype none
module fsp_flash_model (
  // From the controller
  input  wire logic [11:0] addr_i,
  input  wire logic [7:0]  dq_i,
  input  wire logic        ce_n_i,
  input  wire logic        oe_n_i,
  input  wire logic        we_n_i,
  // To the controller
  output wire logic [7:0]  dq_o,
  output wire logic        ready_busy_n_o
);
  // Modes: 1 program, 2 erase, 3 program past its time limit, 4 buffered write aborted
  logic        busy = 1'b0;
  logic [2:0]  mode = 3'h0;
  logic        tog = 1'b0;
  logic [7:0]  datum = 8'hFF;
  logic [7:0]  last = 8'h00;
  logic [7:0]  wd = 8'h00;
  logic [11:0] ra = 12'h000;
  logic [11:0] wa = 12'h000;
  int          cnt = 0;
  int          wn = 0;
  wire  [7:0]  st;
  assign st = {mode == 3'h2 ? 1'b0 : ~datum[7], tog, mode == 3'h3, 1'b0,
               mode == 3'h2, mode == 3'h2 && tog, mode == 3'h4, 1'b0};
  // A released bus shows the inverse of the last byte so a stale sample cannot pass
  assign dq_o = (!ce_n_i && !oe_n_i) ? (busy ? st : datum) : ~last;
  assign ready_busy_n_o = !busy;
  always @(posedge oe_n_i)
  begin
    last = busy ? st : datum;
    ra = addr_i;
    if (busy)
    begin
      tog = ~tog;
      cnt = cnt - 1;
      // Program and erase show status for a bounded time, then array data; modes 3 and 4 stay busy
      if (cnt <= 0 && mode < 3'h3)
        busy = 1'b0;
    end
  end
  // Take address and data once settled inside the strobe; the closing edge races the bus
  always @(negedge we_n_i)
  begin
    #1;
    wa = addr_i;
    wd = dq_i;
  end
  always @(posedge we_n_i)
  begin
    wn = wn + 1;
    if (wd == 8'hF0)
    begin
      busy = 1'b0;
      mode = 3'h0;
    end
  end
endmodule
`default_nettype wire

// *** tb/fsp_top_tb_top.sv ***
// Self-checking bench for the flash status poller
`timescale 1ns/1ps
`default_nettype none
`include "fsp_defs.vh"
module fsp_top_tb_top;
  logic        clk_sys_i = 1'b0;
  logic        rstn_i = 1'b0;
  logic [3:0]  sw_addr_i = 4'h0;
  logic [15:0] sw_wdata_i = 16'h0000;
  logic        sw_wr_i = 1'b0;
  logic        sw_rd_i = 1'b0;
  logic        rd_d = 1'b0;
  logic [15:0] last_rd;
  logic [31:0] nt;
  logic [31:0] q[$];
  logic [7:0]  dat;
  logic [11:0] tgt;
  int          err_count = 0;
  int          cmp_count = 0;
  int          cyc = 0;
  wire  [15:0] sw_rdata_o;
  wire  [11:0] fl_addr_o;
  wire  [7:0]  fl_dq_o;
  wire  [7:0]  fl_dq_i;
  wire  [7:0]  dq_bus;
  wire         fl_dq_oe_o;
  wire         fl_ce_n_o;
  wire         fl_oe_n_o;
  wire         fl_we_n_o;
  wire         fl_ready_busy_n_i;
  // Scenario table: model mode, control word, expected status low nibble, reset writes
  logic [2:0]  mode_t [6] = '{3'h1, 3'h1, 3'h2, 3'h2, 3'h3, 3'h4};
  logic [15:0] ctrl_t [6] = '{16'h0001, 16'h0003, 16'h0001, 16'h0003, 16'h0001, 16'h0005};
  logic [3:0]  st_t [6] = '{4'h2, 4'h2, 4'h2, 4'h2, 4'h7, 4'hB};
  logic [15:0] wr_t [6] = '{16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0001, 16'h0003};
  assign dq_bus = fl_dq_oe_o ? fl_dq_o : fl_dq_i;
  fsp_top #(.AW(12), .DW(8)) i_fsp_top (.clk_sys_i, .rstn_i, .sw_addr_i, .sw_wdata_i,
    .sw_wr_i, .sw_rd_i, .sw_rdata_o, .fl_addr_o, .fl_dq_o, .fl_dq_oe_o, .fl_dq_i,
    .fl_ce_n_o, .fl_oe_n_o, .fl_we_n_o, .fl_ready_busy_n_i);
  fsp_flash_model i_fsp_flash_model (.addr_i(fl_addr_o), .dq_i(dq_bus), .ce_n_i(fl_ce_n_o),
    .oe_n_i(fl_oe_n_o), .we_n_i(fl_we_n_o), .dq_o(fl_dq_i), .ready_busy_n_o(fl_ready_busy_n_i));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic tally_and_finish();
    $display("mismatches %0d comparisons %0d", err_count, cmp_count);
    if (err_count == 0 && cmp_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task automatic check(input string nm, input logic [15:0] e, input logic [15:0] g);
    cmp_count++;
    if (g !== e)
    begin
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
      err_count++;
    end
  endtask
  task automatic sw_write(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk_sys_i);
    sw_addr_i <= a;
    sw_wdata_i <= d;
    sw_wr_i <= 1'b1;
    @(posedge clk_sys_i);
    sw_wr_i <= 1'b0;
  endtask
  // Mask zero only captures the value; the watcher compares the masked bits
  task automatic sw_read(input logic [3:0] a, input logic [15:0] e, input logic [15:0] m);
    @(posedge clk_sys_i);
    sw_addr_i <= a;
    sw_rd_i <= 1'b1;
    q.push_back({m, e & m});
    @(posedge clk_sys_i);
    sw_rd_i <= 1'b0;
    @(posedge clk_sys_i);
    #1;
  endtask
  task automatic wait_done();
    int n;
    n = 0;
    last_rd = 16'h0001;
    while (last_rd[1:0] < 2'h2 && n < 500)
    begin
      sw_read(`FSP_ADDR_STATUS, 16'h0000, 16'h0000);
      n++;
    end
    if (n == 500)
    begin
      $display("CHECK FAILED wait_done expected finish seen timeout");
      err_count++;
    end
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    forever #10 clk_sys_i = ~clk_sys_i;
  end
  always @(posedge clk_sys_i)
  begin
    rd_d <= sw_rd_i;
    cyc++;
    if (rd_d)
    begin
      nt = q.pop_front();
      last_rd = sw_rdata_o;
      if (nt[31:16] != 16'h0000)
        check("sw_rdata", nt[15:0], sw_rdata_o & nt[31:16]);
    end
    if (cyc == 40000)
    begin
      err_count++;
      tally_and_finish();
    end
  end
  initial
  begin
    void'($urandom(52));
    repeat (4) @(posedge clk_sys_i);
    rstn_i <= 1'b1;
    sw_read(`FSP_ADDR_STATUS, 16'h0000, 16'h000F);
    sw_read(4'hF, 16'h0000, 16'hFFFF);
    for (int i = 0; i < 6; i++)
    begin
      dat = (mode_t[i] == 3'h2) ? 8'hFF : 8'($urandom);
      tgt = 12'($urandom);
      i_fsp_flash_model.mode = mode_t[i];
      i_fsp_flash_model.datum = dat;
      i_fsp_flash_model.cnt = 2 + $urandom % 5;
      i_fsp_flash_model.wn = 0;
      i_fsp_flash_model.busy = 1'b1;
      sw_write(`FSP_ADDR_TARGET, {4'h0, tgt});
      sw_write(`FSP_ADDR_EXPECT, {8'h00, dat});
      sw_read(`FSP_ADDR_TARGET, {4'h0, tgt}, 16'h0FFF);
      sw_write(`FSP_ADDR_CTRL, ctrl_t[i]);
      sw_read(`FSP_ADDR_STATUS, 16'h0001, 16'h0013);
      wait_done();
      // Failure is flagged before the recovery writes end; let them finish
      repeat (30) @(posedge clk_sys_i);
      sw_read(`FSP_ADDR_STATUS, {11'h000, 1'b1, st_t[i]}, 16'h001F);
      if (st_t[i] == 4'h2)
        sw_read(`FSP_ADDR_DATA, {8'h00, dat}, 16'h00FF);
      check("poll address", {4'h0, tgt}, {4'h0, i_fsp_flash_model.ra});
      check("reset writes", wr_t[i], 16'(i_fsp_flash_model.wn));
      if (wr_t[i] != 16'h0000)
        check("reset word", 16'h55F0, {i_fsp_flash_model.wa[7:0], i_fsp_flash_model.wd});
    end
    tally_and_finish();
  end
endmodule
`default_nettype wire
